/* File: logic/rcc_pkg.sv */
// constants, encodings and state layout of the radio core control block
// assumes a 32-bit apb bus and one system clock
package rcc_pkg;

    // ----------------------------------------------------------------
    // register byte addresses
    // ----------------------------------------------------------------
    localparam logic [31:0] RCC_CNTL2_ADDR    = 32'h40000200;
    localparam logic [31:0] RCC_EV_STAT_ADDR  = 32'h40000210;
    localparam logic [31:0] RCC_EV_CLEAR_ADDR = 32'h40000214;
    localparam logic [31:0] RCC_EV_EN_ADDR    = 32'h40000218;

    // ----------------------------------------------------------------
    // control register field positions
    // ----------------------------------------------------------------
    localparam int RCC_MHZ_LSB    = 9;
    localparam int RCC_MHZ_MSB    = 14;
    localparam int RCC_PERMIT_BIT = 8;
    localparam int RCC_EDGE_BIT   = 7;
    localparam int RCC_CLKST_BIT  = 6;
    localparam int RCC_FLIP_BIT   = 5;
    localparam int RCC_SRC_LSB    = 3;
    localparam int RCC_SRC_MSB    = 4;
    localparam int RCC_MASK_BIT   = 2;
    localparam int RCC_CLEAR_BIT  = 1;
    localparam int RCC_FLAG_BIT   = 0;

    // ----------------------------------------------------------------
    // event register bit positions
    // ----------------------------------------------------------------
    localparam int RCC_EV_FAULT  = 0;
    localparam int RCC_EV_EDGE   = 1;
    localparam int RCC_EV_PERMIT = 2;
    localparam int RCC_EV_W      = 3;

    // ----------------------------------------------------------------
    // values after reset
    // ----------------------------------------------------------------
    localparam logic [5:0]  RCC_MHZ_RST   = 6'h00;
    localparam logic        RCC_MASK_RST  = 1'b1;
    localparam logic        RCC_FLIP_RST  = 1'b0;
    localparam logic [1:0]  RCC_SRC_RST   = 2'h0;
    localparam logic [2:0]  RCC_EV_EN_RST = 3'h0;
    localparam logic [31:0] RCC_ZERO_WORD = 32'h00000000;

    // slow clock rising edges from sleep request to power-down permit
    localparam logic [1:0]  RCC_PERMIT_EDGES = 2'h2;

    // ----------------------------------------------------------------
    // probe bus source encodings
    // ----------------------------------------------------------------
    localparam logic [1:0] RCC_SRC_CORE      = 2'h0;
    localparam logic [1:0] RCC_SRC_CORE_SLOW = 2'h1;
    localparam logic [1:0] RCC_SRC_RADIO_A   = 2'h2;
    localparam logic [1:0] RCC_SRC_RADIO_B   = 2'h3;

    // ----------------------------------------------------------------
    // power-down permit sequencer states
    // ----------------------------------------------------------------
    typedef enum logic [2:0] {
        RCC_PD_IDLE   = 3'b001,
        RCC_PD_WAIT   = 3'b010,
        RCC_PD_PERMIT = 3'b100
    } rcc_pd_state_t;

    // ----------------------------------------------------------------
    // whole state of the block
    // ----------------------------------------------------------------
    typedef struct packed {
        logic [5:0]    master_clock_mhz;
        logic          core_powerdown_permit;
        logic          slow_clock_edge_seen;
        logic          clock_source_status;
        logic          probe_bus_flip;
        logic [1:0]    probe_bus_source;
        logic          xmem_fault_irq_mask;
        logic          xmem_fault_flag;
        rcc_pd_state_t pd_state;
        logic [1:0]    pd_edges;
        logic          slow_prev;
        logic [2:0]    ev_stat;
        logic [2:0]    ev_en;
        logic          ev_irq;
        logic          core_error_interrupt;
        logic [7:0]    port0_probe;
        logic [3:0]    port1_probe;
        logic          pready;
        logic          pslverr;
        logic [31:0]   prdata;
    } rcc_state_t;

endpackage

/* File: logic/rcc_radio_core_control_two.sv */
// radio core control register two: clock setting, power-down permit,
// slow clock monitor, probe bus mux and exchange memory fault handling
// assumes all inputs synchronous to SYS_CLK, including the slow clock
// which is sampled as a level; apb master follows the usual handshake
//
// Behaviour
// - read-only power-down permit bit 8 rises after sleep request
// - power-down permit clears when the sleep exit interrupt asserts
// - edge monitor bit 7: software writes zero, slow rising edge sets
// - edge monitor not set while timer slow reset holds the timers
// - bit 6 reads 1 on master clock, 0 on low-power clock
// - probe source selects core groups, slow signals or radio groups
// - flip bit 5 reverses probe bus order onto port 0
// - port 1 pins 3:0 copy port 0 pins 3:0
// - fault mask resets to 1; error interrupt follows flag while set
// - fault clear bit 1: one clears flag, zero ignored, reads zero
// - unmapped page access sets read-only fault flag bit 0
`timescale 1ns/1ps

module rcc_radio_core_control_two (
    // clock and reset
    input  wire logic        SYS_CLK,
    input  wire logic        NRST,
    // apb slave
    input  wire logic        PSEL,
    input  wire logic        PENABLE,
    input  wire logic        PWRITE,
    input  wire logic [31:0] PADDR,
    input  wire logic [31:0] PWDATA,
    output logic      [31:0] PRDATA,
    output logic             PREADY,
    output logic             PSLVERR,
    // core status inputs
    input  wire logic        SLOW_CLK,
    input  wire logic        TIMER_SLOW_RESET,
    input  wire logic        DEEP_SLEEP_REQ,
    input  wire logic        SLEEP_EXIT_INTERRUPT,
    input  wire logic        CLOCK_ON_MASTER,
    input  wire logic        XMEM_FAULT_SIGNAL,
    // probe sources
    input  wire logic [7:0]  CORE_PROBE_GROUP_A,
    input  wire logic [7:0]  CORE_PROBE_GROUP_B,
    input  wire logic [7:0]  CORE_PROBE_GROUP_C,
    input  wire logic [7:0]  RADIO_PROBE_GROUP_A,
    input  wire logic [7:0]  RADIO_PROBE_GROUP_B,
    input  wire logic        SLOW_WAKEUP_INTERRUPT,
    input  wire logic        DEEP_SLEEP_STATE_SLOW,
    // settings and probe outputs
    output logic      [5:0]  MASTER_CLOCK_MHZ,
    output logic      [7:0]  PORT0_PROBE,
    output logic      [3:0]  PORT1_PROBE,
    // interrupts
    output logic             CORE_ERROR_INTERRUPT,
    output logic             EVENT_IRQ
);

    // ----------------------------------------------------------------
    // helpers
    // ----------------------------------------------------------------

    // reverse the bit order of a byte
    function automatic logic [7:0] flip8(input logic [7:0] v);
        logic [7:0] r;
        r = 8'h00;
        for (int i = 0; i < 8; i++) begin
            r[i] = v[7 - i];
        end
        return r;
    endfunction

    // ----------------------------------------------------------------
    // state
    // ----------------------------------------------------------------
    rcc_pkg::rcc_state_t st;
    rcc_pkg::rcc_state_t next_st;

    // decoded bus and event terms
    logic        setup;
    logic        wr_done;
    logic        hit_cntl;
    logic        hit_stat;
    logic        hit_clear;
    logic        hit_en;
    logic        slow_rise;
    logic        fault_set;
    logic        fault_clr;
    logic        edge_set;
    logic        permit_rise;
    logic [2:0]  ev_new;
    logic [7:0]  probe_bus;
    logic [7:0]  probe_mapped;
    logic [31:0] cntl_word;

    // ----------------------------------------------------------------
    // address decode and bus phases
    // ----------------------------------------------------------------

    // setup phase seen, write taken at access edge with ready high
    assign setup     = PSEL & ~PENABLE;
    assign wr_done   = PSEL & PENABLE & st.pready & PWRITE;
    assign hit_cntl  = (PADDR == rcc_pkg::RCC_CNTL2_ADDR);
    assign hit_stat  = (PADDR == rcc_pkg::RCC_EV_STAT_ADDR);
    assign hit_clear = (PADDR == rcc_pkg::RCC_EV_CLEAR_ADDR);
    assign hit_en    = (PADDR == rcc_pkg::RCC_EV_EN_ADDR);

    // ----------------------------------------------------------------
    // event terms
    // ----------------------------------------------------------------

    // rising edge of the sampled slow clock
    assign slow_rise = SLOW_CLK & ~st.slow_prev;

    // monitor bit only armed while timers are out of reset
    assign edge_set = slow_rise & ~TIMER_SLOW_RESET;

    // fault flag set by hardware, cleared by a written one
    assign fault_set = XMEM_FAULT_SIGNAL;
    assign fault_clr = wr_done & hit_cntl
                       & PWDATA[rcc_pkg::RCC_CLEAR_BIT];

    // ----------------------------------------------------------------
    // probe bus mux
    // ----------------------------------------------------------------

    // source select for the eight-bit probe bus
    always_comb begin
        case (st.probe_bus_source)
            rcc_pkg::RCC_SRC_CORE: begin
                probe_bus = {CORE_PROBE_GROUP_C[7:5],
                             CORE_PROBE_GROUP_B[4:3],
                             CORE_PROBE_GROUP_A[2:0]};
            end
            rcc_pkg::RCC_SRC_CORE_SLOW: begin
                probe_bus = {CORE_PROBE_GROUP_C[7:5],
                             CORE_PROBE_GROUP_B[4:3],
                             CORE_PROBE_GROUP_A[2],
                             SLOW_WAKEUP_INTERRUPT,
                             DEEP_SLEEP_STATE_SLOW};
            end
            rcc_pkg::RCC_SRC_RADIO_A: begin
                probe_bus = RADIO_PROBE_GROUP_A;
            end
            rcc_pkg::RCC_SRC_RADIO_B: begin
                probe_bus = RADIO_PROBE_GROUP_B;
            end
            default: begin
                probe_bus = 8'h00;
            end
        endcase
    end

    // optional bit reversal before the ports
    assign probe_mapped = st.probe_bus_flip ? flip8(probe_bus)
                                            : probe_bus;

    // ----------------------------------------------------------------
    // control register read view
    // ----------------------------------------------------------------

    // clear bit always reads zero, upper bits zero
    always_comb begin
        cntl_word = rcc_pkg::RCC_ZERO_WORD;
        cntl_word[rcc_pkg::RCC_MHZ_MSB:rcc_pkg::RCC_MHZ_LSB] =
            st.master_clock_mhz;
        cntl_word[rcc_pkg::RCC_PERMIT_BIT] = st.core_powerdown_permit;
        cntl_word[rcc_pkg::RCC_EDGE_BIT]   = st.slow_clock_edge_seen;
        cntl_word[rcc_pkg::RCC_CLKST_BIT]  = st.clock_source_status;
        cntl_word[rcc_pkg::RCC_FLIP_BIT]   = st.probe_bus_flip;
        cntl_word[rcc_pkg::RCC_SRC_MSB:rcc_pkg::RCC_SRC_LSB] =
            st.probe_bus_source;
        cntl_word[rcc_pkg::RCC_MASK_BIT]   = st.xmem_fault_irq_mask;
        cntl_word[rcc_pkg::RCC_FLAG_BIT]   = st.xmem_fault_flag;
    end

    // ----------------------------------------------------------------
    // next state
    // ----------------------------------------------------------------
    always_comb begin
        next_st = st;

        // slow clock sample for edge detection
        next_st.slow_prev = SLOW_CLK;

        // clock source status follows the core clock mux
        next_st.clock_source_status = CLOCK_ON_MASTER;

        // software-writable fields
        if (wr_done && hit_cntl) begin
            next_st.master_clock_mhz =
                PWDATA[rcc_pkg::RCC_MHZ_MSB:rcc_pkg::RCC_MHZ_LSB];
            next_st.probe_bus_flip   = PWDATA[rcc_pkg::RCC_FLIP_BIT];
            next_st.probe_bus_source =
                PWDATA[rcc_pkg::RCC_SRC_MSB:rcc_pkg::RCC_SRC_LSB];
            next_st.xmem_fault_irq_mask = PWDATA[rcc_pkg::RCC_MASK_BIT];
            // only a written zero touches the monitor bit
            if (!PWDATA[rcc_pkg::RCC_EDGE_BIT]) begin
                next_st.slow_clock_edge_seen = 1'b0;
            end
        end

        // hardware set of the monitor bit wins over a written zero
        if (edge_set) begin
            next_st.slow_clock_edge_seen = 1'b1;
        end

        // fault flag: set wins over clear
        if (fault_clr) begin
            next_st.xmem_fault_flag = 1'b0;
        end
        if (fault_set) begin
            next_st.xmem_fault_flag = 1'b1;
        end

        // power-down permit sequencer on slow clock edges
        case (st.pd_state)
            rcc_pkg::RCC_PD_IDLE: begin
                next_st.pd_edges = 2'h0;
                if (DEEP_SLEEP_REQ) begin
                    next_st.pd_state = rcc_pkg::RCC_PD_WAIT;
                end
            end
            rcc_pkg::RCC_PD_WAIT: begin
                if (slow_rise) begin
                    next_st.pd_edges = st.pd_edges + 2'h1;
                    if (st.pd_edges + 2'h1 == rcc_pkg::RCC_PERMIT_EDGES) begin
                        next_st.pd_state = rcc_pkg::RCC_PD_PERMIT;
                        next_st.core_powerdown_permit = 1'b1;
                    end
                end
            end
            rcc_pkg::RCC_PD_PERMIT: begin
                next_st.core_powerdown_permit = 1'b1;
            end
            default: begin
                next_st.pd_state = rcc_pkg::RCC_PD_IDLE;
                next_st.core_powerdown_permit = 1'b0;
            end
        endcase

        // sleep exit drops the permit and restarts the sequence
        if (SLEEP_EXIT_INTERRUPT) begin
            next_st.pd_state = rcc_pkg::RCC_PD_IDLE;
            next_st.core_powerdown_permit = 1'b0;
            next_st.pd_edges = 2'h0;
        end

        // permit rise against the settled sequencer, no loop through nets
        permit_rise = ~st.core_powerdown_permit
                      & next_st.core_powerdown_permit;
        ev_new      = {permit_rise, edge_set, fault_set};

        // event enable register
        if (wr_done && hit_en) begin
            next_st.ev_en = PWDATA[rcc_pkg::RCC_EV_W - 1:0];
        end

        // sticky events: written ones clear, new events win
        if (wr_done && hit_clear) begin
            next_st.ev_stat = st.ev_stat & ~PWDATA[rcc_pkg::RCC_EV_W - 1:0];
        end
        next_st.ev_stat = next_st.ev_stat | ev_new;

        // interrupt outputs registered from the next values
        next_st.ev_irq = |(next_st.ev_stat & next_st.ev_en);
        next_st.core_error_interrupt = next_st.xmem_fault_flag
                                       & next_st.xmem_fault_irq_mask;

        // probe ports, port 1 mirrors port 0 low nibble
        next_st.port0_probe = probe_mapped;
        next_st.port1_probe = probe_mapped[3:0];

        // apb answer prepared in setup, ready during access phase
        next_st.pready  = setup;
        next_st.pslverr = 1'b0;
        next_st.prdata  = rcc_pkg::RCC_ZERO_WORD;
        if (setup) begin
            if (hit_cntl) begin
                next_st.prdata = cntl_word;
            end else if (hit_stat) begin
                next_st.prdata[rcc_pkg::RCC_EV_W - 1:0] = st.ev_stat;
            end else if (hit_en) begin
                next_st.prdata[rcc_pkg::RCC_EV_W - 1:0] = st.ev_en;
            end else if (!hit_clear) begin
                next_st.pslverr = 1'b1;
            end
        end
    end

    // ----------------------------------------------------------------
    // state register
    // ----------------------------------------------------------------
    always_ff @(posedge SYS_CLK or negedge NRST) begin
        if (!NRST) begin
            st.master_clock_mhz      <= rcc_pkg::RCC_MHZ_RST;
            st.core_powerdown_permit <= 1'b0;
            st.slow_clock_edge_seen  <= 1'b0;
            st.clock_source_status   <= 1'b0;
            st.probe_bus_flip        <= rcc_pkg::RCC_FLIP_RST;
            st.probe_bus_source      <= rcc_pkg::RCC_SRC_RST;
            st.xmem_fault_irq_mask   <= rcc_pkg::RCC_MASK_RST;
            st.xmem_fault_flag       <= 1'b0;
            st.pd_state              <= rcc_pkg::RCC_PD_IDLE;
            st.pd_edges              <= 2'h0;
            st.slow_prev             <= 1'b0;
            st.ev_stat               <= 3'h0;
            st.ev_en                 <= rcc_pkg::RCC_EV_EN_RST;
            st.ev_irq                <= 1'b0;
            st.core_error_interrupt  <= 1'b0;
            st.port0_probe           <= 8'h00;
            st.port1_probe           <= 4'h0;
            st.pready                <= 1'b0;
            st.pslverr               <= 1'b0;
            st.prdata                <= rcc_pkg::RCC_ZERO_WORD;
        end else begin
            st <= next_st;
        end
    end

    // ----------------------------------------------------------------
    // outputs
    // ----------------------------------------------------------------

    // every output is a state flip-flop
    assign PRDATA               = st.prdata;
    assign PREADY               = st.pready;
    assign PSLVERR              = st.pslverr;
    assign MASTER_CLOCK_MHZ     = st.master_clock_mhz;
    assign PORT0_PROBE          = st.port0_probe;
    assign PORT1_PROBE          = st.port1_probe;
    assign CORE_ERROR_INTERRUPT = st.core_error_interrupt;
    assign EVENT_IRQ            = st.ev_irq;

endmodule

/* File: verification/rcc_props.sv */
// checker: apb answer, fault interrupt and probe copy relations
// assumes binding onto the radio core control two top module
`timescale 1ns/1ps
module rcc_props (
    // clock, reset and apb
    input wire logic        SYS_CLK,
    input wire logic        NRST,
    input wire logic        PSEL,
    input wire logic        PENABLE,
    input wire logic        PWRITE,
    input wire logic [31:0] PADDR,
    input wire logic [31:0] PWDATA,
    input wire logic [31:0] PRDATA,
    input wire logic        PREADY,
    input wire logic        PSLVERR,
    // fault input and outputs
    input wire logic        XMEM_FAULT_SIGNAL,
    input wire logic [5:0]  MASTER_CLOCK_MHZ,
    input wire logic [7:0]  PORT0_PROBE,
    input wire logic [3:0]  PORT1_PROBE,
    input wire logic        CORE_ERROR_INTERRUPT
);
    logic wr_ctl;
    logic hit;
    logic mask_copy;

    // control write completing, and decode of mapped words
    assign wr_ctl = PSEL && PENABLE && PREADY && PWRITE
                    && PADDR == rcc_pkg::RCC_CNTL2_ADDR;
    assign hit = PADDR inside {rcc_pkg::RCC_CNTL2_ADDR,
        rcc_pkg::RCC_EV_STAT_ADDR, rcc_pkg::RCC_EV_CLEAR_ADDR,
        rcc_pkg::RCC_EV_EN_ADDR};

    // copy of the fault mask, high after reset
    always_ff @(posedge SYS_CLK or negedge NRST) begin
        if (!NRST)
            mask_copy <= 1'b1;
        else if (wr_ctl)
            mask_copy <= PWDATA[2];
    end

    default clocking @(posedge SYS_CLK); endclocking
    default disable iff (!NRST);

    chk_ready_setup: assert property (PSEL && !PENABLE |=> PREADY)
        else $error("ready missing after setup");
    chk_ready_single: assert property (PREADY |=> !PREADY)
        else $error("ready held too long");
    chk_err_unmapped: assert property (PREADY |-> PSLVERR == !hit)
        else $error("error flag wrong for address");
    chk_clear_zero: assert property (
        PREADY && !PWRITE && PADDR == rcc_pkg::RCC_CNTL2_ADDR
        |-> PRDATA[1] == 1'b0)
        else $error("clear bit read back nonzero");
    chk_rate_write: assert property (
        wr_ctl |=> MASTER_CLOCK_MHZ == $past(PWDATA[14:9]))
        else $error("clock rate not taken");
    chk_port1_copy: assert property (
        PORT1_PROBE == PORT0_PROBE[3:0])
        else $error("port one differs");
    chk_irq_rise: assert property (
        $rose(CORE_ERROR_INTERRUPT)
        |-> $past(XMEM_FAULT_SIGNAL) || $past(wr_ctl))
        else $error("error interrupt rose without cause");
    chk_irq_fall: assert property (
        $fell(CORE_ERROR_INTERRUPT) |-> $past(wr_ctl))
        else $error("error interrupt fell without write");
    chk_fault_irq: assert property (
        XMEM_FAULT_SIGNAL && mask_copy && !wr_ctl
        |=> CORE_ERROR_INTERRUPT)
        else $error("unmasked fault gave no interrupt");
endmodule

bind rcc_radio_core_control_two rcc_props rcc_props_i (
    .SYS_CLK(SYS_CLK), .NRST(NRST), .PSEL(PSEL), .PENABLE(PENABLE),
    .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA),
    .PREADY(PREADY), .PSLVERR(PSLVERR),
    .XMEM_FAULT_SIGNAL(XMEM_FAULT_SIGNAL),
    .MASTER_CLOCK_MHZ(MASTER_CLOCK_MHZ), .PORT0_PROBE(PORT0_PROBE),
    .PORT1_PROBE(PORT1_PROBE), .CORE_ERROR_INTERRUPT(CORE_ERROR_INTERRUPT)
);

/* File: verification/rcc_radio_core_control_two_tb.sv */
// bench: apb register sequences with expected values
// assumes the design package and the bound checker
`timescale 1ns/1ps
module rcc_radio_core_control_two_tb;
    localparam logic [31:0] ctl  = rcc_pkg::RCC_CNTL2_ADDR;
    localparam logic [31:0] base = 32'h00001004;
    // apb, status and probe stimulus
    logic        clk, nrst, psel, penable, pwrite, pready, pslverr, er;
    logic        slow, tsr, dsr, sxi, com, flt, wk, ds, cirq, eirq;
    logic [31:0] paddr, pwdata, prdata, rd;
    logic [7:0]  ga, gb, gc, ra, rb, p0;
    logic [3:0]  p1;
    logic [5:0]  mhz;
    int          num_errors = 0;
    int          tests_run = 0;
    int          cycles = 0;

    rcc_radio_core_control_two rcc_radio_core_control_two_i (
        .SYS_CLK(clk), .NRST(nrst), .PSEL(psel), .PENABLE(penable),
        .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata),
        .PREADY(pready), .PSLVERR(pslverr), .SLOW_CLK(slow),
        .TIMER_SLOW_RESET(tsr), .DEEP_SLEEP_REQ(dsr),
        .SLEEP_EXIT_INTERRUPT(sxi), .CLOCK_ON_MASTER(com),
        .XMEM_FAULT_SIGNAL(flt), .CORE_PROBE_GROUP_A(ga),
        .CORE_PROBE_GROUP_B(gb), .CORE_PROBE_GROUP_C(gc),
        .RADIO_PROBE_GROUP_A(ra), .RADIO_PROBE_GROUP_B(rb),
        .SLOW_WAKEUP_INTERRUPT(wk), .DEEP_SLEEP_STATE_SLOW(ds),
        .MASTER_CLOCK_MHZ(mhz), .PORT0_PROBE(p0), .PORT1_PROBE(p1),
        .CORE_ERROR_INTERRUPT(cirq), .EVENT_IRQ(eirq)
    );

    // system clock, 40 ns period
    always #20 clk = ~clk;

    // cycle ceiling cuts a hang short
    always @(posedge clk) begin
        cycles++;
        if (cycles == 5000) begin
            num_errors++;
            report_and_stop();
        end
    end

    // ------------------------------------------------------------
    // tasks
    // ------------------------------------------------------------
    task automatic check(input string n, input logic [31:0] s, e);
        tests_run++;
        if (s !== e) begin
            num_errors++;
            $display("MISMATCH %s exp=%h seen=%h", n, e, s);
        end
    endtask

    // one apb transfer, holds until ready is sampled high
    task automatic apb(input logic w, input logic [31:0] a, d);
        @(posedge clk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        do @(posedge clk); while (pready !== 1'b1);
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic rdchk(input string n, input logic [31:0] a, m, e);
        apb(1'b0, a, 32'h00000000);
        check(n, rd & m, e);
    endtask

    task automatic tick(input int k);
        repeat (k) @(posedge clk);
    endtask

    // one slow clock period, high for two system cycles
    task automatic slow_edge();
        @(posedge clk);
        slow <= 1'b1;
        tick(2);
        slow <= 1'b0;
        tick(2);
    endtask

    function automatic logic [7:0] probe_exp(input logic [1:0] s,
                                             input logic f);
        logic [7:0] v;
        case (s)
            2'h0: v = {gc[7:5], gb[4:3], ga[2:0]};
            2'h1: v = {gc[7:5], gb[4:3], ga[2], wk, ds};
            2'h2: v = ra;
            default: v = rb;
        endcase
        if (f)
            v = {<<{v}};
        return v;
    endfunction

    task automatic report_and_stop();
        $display("errors %0d checks %0d", num_errors, tests_run);
        if (num_errors == 0 && tests_run > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask

    // ------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------
    initial begin
        logic [7:0] e8;
        clk = 1'b0;
        nrst = 1'b0;
        {psel, penable, pwrite, slow, tsr, dsr, sxi, com, flt, ds} = '0;
        {paddr, pwdata} = '0;
        wk = 1'b1;
        {ga, gb, gc, ra, rb} = 40'hC396E13C17;
        tick(10);
        nrst <= 1'b1;
        rdchk("ctl_reset", ctl, 32'hFFFFFFFF, 32'h00000004);
        // rate field, with the clear bit written as one
        for (int i = 16; i >= 8; i -= 8) begin
            apb(1'b1, ctl, (32'(i) << 9) | 32'h00000006);
            rdchk("ctl_rate", ctl, 32'h00007E06, (32'(i) << 9) | 32'h4);
            check("rate_out", 32'(mhz), 32'(i));
        end
        // clock source status follows the active clock
        for (int i = 0; i < 2; i++) begin
            com <= i[0];
            tick(2);
            rdchk("clk_stat", ctl, 32'h00000040, 32'(i) << 6);
        end
        // edge monitor held off in timer reset, then set
        tsr <= 1'b1;
        slow_edge();
        rdchk("edge_held", ctl, 32'h00000080, 32'h00000000);
        tsr <= 1'b0;
        slow_edge();
        apb(1'b1, ctl, base | 32'h00000080);
        rdchk("edge_set", ctl, 32'h00000080, 32'h00000080);
        apb(1'b1, ctl, base);
        rdchk("edge_zero", ctl, 32'h00000080, 32'h00000000);
        // fault flag, interrupt and event path
        @(posedge clk);
        flt <= 1'b1;
        @(posedge clk);
        flt <= 1'b0;
        apb(1'b1, ctl, base);
        rdchk("flag_set", ctl, 32'h00000001, 32'h00000001);
        check("err_irq", 32'(cirq), 32'h00000001);
        check("ev_irq_off", 32'(eirq), 32'h00000000);
        apb(1'b1, rcc_pkg::RCC_EV_EN_ADDR, 32'h00000001);
        tick(1);
        check("ev_irq_on", 32'(eirq), 32'h00000001);
        apb(1'b1, rcc_pkg::RCC_EV_CLEAR_ADDR, 32'h00000001);
        tick(1);
        check("ev_irq_clr", 32'(eirq), 32'h00000000);
        rdchk("ev_stat", rcc_pkg::RCC_EV_STAT_ADDR, 32'h1, 32'h0);
        // fault held over a clear write keeps the flag
        flt <= 1'b1;
        apb(1'b1, ctl, base | 32'h00000002);
        flt <= 1'b0;
        rdchk("flag_kept", ctl, 32'h00000001, 32'h00000001);
        apb(1'b1, ctl, base | 32'h00000002);
        rdchk("flag_clr", ctl, 32'h00000001, 32'h00000000);
        check("err_irq_clr", 32'(cirq), 32'h00000000);
        // masked fault sets the flag only, unmasking raises it
        apb(1'b1, ctl, 32'h00001000);
        flt <= 1'b1;
        tick(1);
        flt <= 1'b0;
        rdchk("flag_mask", ctl, 32'h00000001, 32'h00000001);
        check("irq_masked", 32'(cirq), 32'h00000000);
        apb(1'b1, ctl, base);
        tick(1);
        check("irq_unmask", 32'(cirq), 32'h00000001);
        apb(1'b1, ctl, base | 32'h00000002);
        // power-down permit after sleep request, dropped on exit
        dsr <= 1'b1;
        repeat (3) slow_edge();
        rdchk("permit_on", ctl, 32'h00000100, 32'h00000100);
        dsr <= 1'b0;
        sxi <= 1'b1;
        tick(1);
        sxi <= 1'b0;
        rdchk("permit_off", ctl, 32'h00000100, 32'h00000000);
        rdchk("ev_late", rcc_pkg::RCC_EV_STAT_ADDR, 32'h6, 32'h6);
        // every probe source in both bit orders
        for (int s = 0; s < 4; s++) begin
            for (int f = 0; f < 2; f++) begin
                e8 = probe_exp(s[1:0], f[0]);
                apb(1'b1, ctl, base | (32'(f) << 5) | (32'(s) << 3));
                tick(2);
                check("port0", 32'(p0), 32'(e8));
                check("port1", 32'(p1), 32'(e8[3:0]));
            end
        end
        // unmapped word answers with an error and zero
        apb(1'b0, 32'h40000220, 32'h00000000);
        check("unmapped_err", 32'(er), 32'h00000001);
        check("unmapped_data", rd, 32'h00000000);
        // second reset mid-run restores defaults
        nrst <= 1'b0;
        tick(2);
        nrst <= 1'b1;
        rdchk("ctl_reset2", ctl, 32'h00007E3D, 32'h00000004);
        check("mhz_reset2", 32'(mhz), 32'h00000000);
        report_and_stop();
    end
endmodule
